/* File: inc/watchdog_reset_sleep_pkg.sv */
// Constants for the reset-timing, watchdog and sleep block
package watchdog_reset_sleep_pkg;

   // Reference clock rate
   localparam int unsigned CLK_FREQ_KHZ       = 250000;

   // Reset delay timer nominal period
   localparam int unsigned RESET_DELAY_US     = 18000;
   localparam int unsigned RESET_DELAY_CYCLES = (RESET_DELAY_US * (CLK_FREQ_KHZ / 1000));

   // Watchdog base period, prescaler not assigned
   localparam int unsigned WATCHDOG_BASE_US     = 18000;
   localparam int unsigned WATCHDOG_BASE_CYCLES = (WATCHDOG_BASE_US * (CLK_FREQ_KHZ / 1000));

   // Prescaler configuration layout
   localparam int unsigned CFG_WIDTH               = 6;
   localparam logic [5:0]  CFG_RESET_VALUE         = 6'h3f;
   localparam int unsigned CFG_CLOCK_SOURCE_POS    = 5;
   localparam int unsigned CFG_EDGE_SELECT_POS     = 4;
   localparam int unsigned CFG_PRESCALER_ASSIGN_POS = 3;
   localparam int unsigned CFG_RATIO_LSB           = 0;
   localparam int unsigned CFG_RATIO_WIDTH         = 3;

   // Prescaler counter width, largest ratio 1:128
   localparam int unsigned PRESCALER_WIDTH = 7;

   // Status flag values after power-up
   localparam logic        TIMEOUT_FLAG_RESET   = 1'b1;
   localparam logic        POWERDOWN_FLAG_RESET = 1'b1;

   // I/O pins held across sleep
   localparam int unsigned IO_PIN_COUNT = 12;

endpackage

/* File: design/watchdog_reset_sleep_control.sv */
// Reset delay timer, watchdog counter, sleep control and reset-cause flags
// Notes on behaviour
// - Delay timer holds processor in reset
// - Delay counts after master clear goes high
// - Watchdog time-out restarts the delay timer
// - Watchdog runs on own clock during sleep
// - Watchdog time-out gives full device reset
// - Time-out clears timeout flag, keeps powerdown flag
// - Fuse at zero disables watchdog while held low
// - Base period 18 ms, prescaled to 1:128
// - Watchdog clear resets counter, sets both flags
// - Sleep clears watchdog, sets timeout, clears powerdown
// - Flag pair encodes the last reset cause
// - Only four events change the status flags
// - Events act regardless of current flag values
// - Pins keep their drive state in sleep
// - Watchdog reset never drives master clear pin
// - Only master clear or time-out wakes
// - Watchdog cleared on every wake-up
// - Wake-up restarts through the reset path
`timescale 1ns/1ps
`default_nettype none

module watchdog_reset_sleep_control
   import watchdog_reset_sleep_pkg::*;
#(
   parameter int unsigned RESET_DELAY_CNT = RESET_DELAY_CYCLES,
   parameter int unsigned WATCHDOG_CNT    = WATCHDOG_BASE_CYCLES,
   parameter int unsigned PIN_COUNT       = IO_PIN_COUNT
) (
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_reset,
   input  wire logic                 i_master_clear_pin_n,
   input  wire logic                 i_watchdog_enable_fuse,
   input  wire logic                 i_watchdog_clear_instr,
   input  wire logic                 i_sleep_instr,
   input  wire logic                 i_prescaler_config_wr,
   input  wire logic [CFG_WIDTH-1:0] i_prescaler_config_data,
   input  wire logic [PIN_COUNT-1:0] i_port_out,
   input  wire logic [PIN_COUNT-1:0] i_port_oe,
   output logic                      o_core_reset,
   output logic                      o_timeout_flag,
   output logic                      o_powerdown_flag,
   output logic                      o_sleeping,
   output logic                      o_osc_driver_en,
   output logic                      o_watchdog_timeout,
   output logic [CFG_WIDTH-1:0]      o_prescaler_config,
   output logic [PIN_COUNT-1:0]      o_port_out,
   output logic [PIN_COUNT-1:0]      o_port_oe,
   output logic                      o_master_clear_pin_oe
);

   localparam int unsigned DELAY_W = (RESET_DELAY_CNT > 1) ? $clog2(RESET_DELAY_CNT) : 1;
   localparam int unsigned WDOG_W  = (WATCHDOG_CNT > 1) ? $clog2(WATCHDOG_CNT) : 1;
   localparam logic [DELAY_W-1:0] DELAY_LAST = DELAY_W'(RESET_DELAY_CNT - 1);
   localparam logic [WDOG_W-1:0]  WDOG_LAST  = WDOG_W'(WATCHDOG_CNT - 1);

   typedef enum logic [1:0] {
      ST_HOLD,
      ST_DELAY,
      ST_RUN,
      ST_SLEEP
   } phase_t;

   typedef struct packed {
      phase_t                     phase;
      logic [DELAY_W-1:0]         delay_cnt;
      logic [WDOG_W-1:0]          wdog_cnt;
      logic [PRESCALER_WIDTH-1:0] presc_cnt;
      logic                       timeout_flag;
      logic                       powerdown_flag;
      logic [CFG_WIDTH-1:0]       prescaler_config;
      logic [PIN_COUNT-1:0]       port_out;
      logic [PIN_COUNT-1:0]       port_oe;
      logic                       core_reset;
      logic                       osc_driver_en;
      logic                       timeout_pulse;
      logic                       master_clear_pin_oe;
      logic                       sleeping;
   } state_t;

   // Events allowed to change the flag pair
   typedef enum logic [1:0] {
      EV_NONE,
      EV_TIMEOUT,
      EV_SLEEP,
      EV_CLEAR
   } flag_event_t;

   state_t state_reg;
   state_t state_next;

   // Mask of prescaler bits that must all be one for a tick
   function automatic logic [PRESCALER_WIDTH-1:0] ratio_mask(input logic [CFG_RATIO_WIDTH-1:0] ratio);
      logic [PRESCALER_WIDTH:0] one_hot;
      one_hot = (PRESCALER_WIDTH+1)'(1) << ratio;
      ratio_mask = PRESCALER_WIDTH'(one_hot - (PRESCALER_WIDTH+1)'(1));
   endfunction

   // Phases in which the watchdog oscillator advances the counter
   function automatic logic watchdog_phase(input phase_t phase);
      watchdog_phase = (phase == ST_RUN) || (phase == ST_SLEEP);
   endfunction

   // Only a running core issues instructions
   function automatic logic core_running(input phase_t phase);
      core_running = (phase == ST_RUN);
   endfunction

   // Flag pair, timeout then powerdown, after one event
   function automatic logic [1:0] next_flags(input flag_event_t event_kind,
                                             input logic [1:0]  flags);
      case (event_kind)
         EV_TIMEOUT: begin
            next_flags = {1'b0, flags[0]};
         end
         EV_SLEEP: begin
            next_flags = 2'h2;
         end
         EV_CLEAR: begin
            next_flags = 2'h3;
         end
         default: begin
            next_flags = flags;
         end
      endcase
   endfunction

   logic                        presc_assigned;
   logic [CFG_RATIO_WIDTH-1:0]  ratio_sel;
   logic                        wdog_tick;
   logic                        wdog_expire;
   logic                        wdog_active;
   logic                        master_clear_low;
   logic                        sleep_take;
   logic                        clear_take;
   logic                        config_take;
   flag_event_t                 flag_event;

   // Prescaler assignment and ratio fields
   assign presc_assigned = state_reg.prescaler_config[CFG_PRESCALER_ASSIGN_POS];
   assign ratio_sel      = state_reg.prescaler_config[CFG_RATIO_LSB +: CFG_RATIO_WIDTH];

   // Watchdog counts only while code runs or the core sleeps
   assign wdog_active = i_watchdog_enable_fuse &&
                        watchdog_phase(state_reg.phase);

   // Prescaler output ticks once per selected ratio
   assign wdog_tick = !presc_assigned ||
                      ((state_reg.presc_cnt & ratio_mask(ratio_sel)) == ratio_mask(ratio_sel));

   assign wdog_expire = wdog_active && wdog_tick && (state_reg.wdog_cnt == WDOG_LAST);

   // Master clear low overrides every other event
   assign master_clear_low = !i_master_clear_pin_n;

   // Core instructions by priority: sleep, clear, then write
   assign sleep_take  = core_running(state_reg.phase) && i_sleep_instr;
   assign clear_take  = core_running(state_reg.phase) && !i_sleep_instr && i_watchdog_clear_instr;
   assign config_take = core_running(state_reg.phase) && !i_sleep_instr && !i_watchdog_clear_instr &&
                        i_prescaler_config_wr;

   // Event that decides the flag pair this cycle
   assign flag_event = master_clear_low ? EV_NONE    :
                       wdog_expire      ? EV_TIMEOUT :
                       sleep_take       ? EV_SLEEP   :
                       clear_take       ? EV_CLEAR   :
                                          EV_NONE;

   always_comb begin
      state_next               = state_reg;
      state_next.timeout_pulse = 1'b0;

      // Watchdog reset stays internal
      state_next.master_clear_pin_oe = 1'b0;

      // Pins follow the core except while asleep
      if (state_reg.phase != ST_SLEEP) begin
         state_next.port_out = i_port_out;
         state_next.port_oe  = i_port_oe;
      end

      // Watchdog and prescaler advance on their own clock
      if (wdog_active) begin
         if (presc_assigned) begin
            state_next.presc_cnt = state_reg.presc_cnt + PRESCALER_WIDTH'(1);
         end

         if (wdog_tick) begin
            state_next.wdog_cnt = state_reg.wdog_cnt + WDOG_W'(1);
         end
      end else begin
         // Reset and delay phases keep both counters cleared
         state_next.presc_cnt = '0;
         state_next.wdog_cnt  = '0;
      end

      case (state_reg.phase)
         ST_HOLD: begin
            // Delay timer waits for master clear high
            state_next.core_reset = 1'b1;
            state_next.delay_cnt  = '0;

            if (i_master_clear_pin_n) begin
               state_next.phase = ST_DELAY;
            end
         end

         ST_DELAY: begin
            state_next.core_reset = 1'b1;

            if (state_reg.delay_cnt == DELAY_LAST) begin
               state_next.phase      = ST_RUN;
               state_next.core_reset = 1'b0;
               state_next.delay_cnt  = '0;
            end else begin
               state_next.delay_cnt = state_reg.delay_cnt + DELAY_W'(1);
            end
         end

         ST_RUN: begin
            state_next.core_reset = 1'b0;

            if (sleep_take) begin
               // Enter sleep with a fresh watchdog
               state_next.phase     = ST_SLEEP;
               state_next.wdog_cnt  = '0;
               state_next.presc_cnt = '0;

               state_next.osc_driver_en = 1'b0;

               // Pins hold what they drove before the instruction
               state_next.port_out = state_reg.port_out;
               state_next.port_oe  = state_reg.port_oe;
            end else if (clear_take) begin
               state_next.wdog_cnt  = '0;
               state_next.presc_cnt = '0;
            end else if (config_take) begin
               state_next.prescaler_config = i_prescaler_config_data;
            end
         end

         ST_SLEEP: begin
            // Main oscillator stays off until a wake-up
            state_next.osc_driver_en = 1'b0;
         end

         default: begin
            state_next.phase = ST_HOLD;
         end
      endcase

      // Watchdog time-out: internal reset through the delay timer
      if (wdog_expire) begin
         state_next.phase         = ST_DELAY;
         state_next.delay_cnt     = '0;
         state_next.core_reset    = 1'b1;
         state_next.timeout_pulse = 1'b1;

         state_next.wdog_cnt  = '0;
         state_next.presc_cnt = '0;

         state_next.osc_driver_en    = 1'b1;
         state_next.prescaler_config = CFG_RESET_VALUE;
      end

      // Master clear low: reset or wake, flags untouched
      if (master_clear_low) begin
         state_next.phase         = ST_HOLD;
         state_next.delay_cnt     = '0;
         state_next.core_reset    = 1'b1;
         state_next.timeout_pulse = 1'b0;

         state_next.wdog_cnt  = '0;
         state_next.presc_cnt = '0;

         state_next.osc_driver_en    = 1'b1;
         state_next.prescaler_config = CFG_RESET_VALUE;
      end

      // Only the four listed events touch the flags
      {state_next.timeout_flag, state_next.powerdown_flag} =
         next_flags(flag_event, {state_reg.timeout_flag, state_reg.powerdown_flag});

      // Sleep indication registered with the phase
      state_next.sleeping = (state_next.phase == ST_SLEEP);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         // Power-up: both flags set, core held
         state_reg.phase     <= ST_HOLD;
         state_reg.sleeping  <= 1'b0;

         // Counters
         state_reg.delay_cnt <= '0;
         state_reg.wdog_cnt  <= '0;
         state_reg.presc_cnt <= '0;

         // Reset-cause flags
         state_reg.timeout_flag   <= TIMEOUT_FLAG_RESET;
         state_reg.powerdown_flag <= POWERDOWN_FLAG_RESET;

         // Configuration and pins
         state_reg.prescaler_config <= CFG_RESET_VALUE;
         state_reg.port_out         <= '0;
         state_reg.port_oe          <= '0;

         // Core, oscillator and pulses
         state_reg.core_reset    <= 1'b1;
         state_reg.osc_driver_en <= 1'b1;
         state_reg.timeout_pulse <= 1'b0;
         state_reg.master_clear_pin_oe       <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Every output is a field of the state register
   assign o_core_reset          = state_reg.core_reset;
   assign o_timeout_flag        = state_reg.timeout_flag;
   assign o_powerdown_flag      = state_reg.powerdown_flag;
   assign o_sleeping            = state_reg.sleeping;
   assign o_osc_driver_en       = state_reg.osc_driver_en;
   assign o_watchdog_timeout    = state_reg.timeout_pulse;

   assign o_prescaler_config    = state_reg.prescaler_config;

   assign o_port_out            = state_reg.port_out;
   assign o_port_oe             = state_reg.port_oe;

   assign o_master_clear_pin_oe = state_reg.master_clear_pin_oe;

endmodule

`default_nettype wire

/* File: verification/wrs_checker.sv */
// Port checker for the reset, watchdog and sleep block
`timescale 1ns/1ps
`default_nettype none
module wrs_checker
   import watchdog_reset_sleep_pkg::*;
#(
   parameter int unsigned RESET_DELAY_CNT = 20,
   parameter int unsigned PIN_COUNT       = 12
) (
   input wire logic                 i_ref_clk,
   input wire logic                 i_reset,
   input wire logic                 i_master_clear_pin_n,
   input wire logic                 i_watchdog_enable_fuse,
   input wire logic                 i_watchdog_clear_instr,
   input wire logic                 i_sleep_instr,
   input wire logic                 o_core_reset,
   input wire logic                 o_timeout_flag,
   input wire logic                 o_powerdown_flag,
   input wire logic                 o_sleeping,
   input wire logic                 o_osc_driver_en,
   input wire logic                 o_watchdog_timeout,
   input wire logic [CFG_WIDTH-1:0] o_prescaler_config,
   input wire logic [PIN_COUNT-1:0] o_port_out,
   input wire logic [PIN_COUNT-1:0] o_port_oe,
   input wire logic                 o_master_clear_pin_oe
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   logic [31:0] hi_cnt_reg;
   logic        run;
   assign run = !o_core_reset && !o_sleeping && i_master_clear_pin_n;
   // Cycles of pin high since the last reset cause
   always_ff @(posedge i_ref_clk) begin
      if (i_reset || !i_master_clear_pin_n || o_watchdog_timeout) hi_cnt_reg <= '0;
      else hi_cnt_reg <= hi_cnt_reg + 32'h1;
   end
   property p_delay; $fell(o_core_reset) |-> hi_cnt_reg >= RESET_DELAY_CNT - 1; endproperty
   a_delay: assert property (p_delay) else $error("core left reset too early");
   property p_to; o_watchdog_timeout |-> o_core_reset && !o_timeout_flag && !o_sleeping && o_osc_driver_en; endproperty
   a_to: assert property (p_to) else $error("time-out without reset");
   property p_pd_keep; o_watchdog_timeout |-> o_powerdown_flag == $past(o_powerdown_flag); endproperty
   a_pd_keep: assert property (p_pd_keep) else $error("time-out changed powerdown flag");
   property p_fuse; !i_watchdog_enable_fuse && !$past(i_watchdog_enable_fuse) |-> !o_watchdog_timeout; endproperty
   a_fuse: assert property (p_fuse) else $error("time-out with watchdog fused off");
   property p_sleep; i_sleep_instr && run |=> o_watchdog_timeout ||
      (o_sleeping && o_timeout_flag && !o_powerdown_flag && !o_osc_driver_en); endproperty
   a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
   property p_clear; i_watchdog_clear_instr && !i_sleep_instr && run |=> o_watchdog_timeout ||
      (o_timeout_flag && o_powerdown_flag); endproperty
   a_clear: assert property (p_clear) else $error("watchdog clear flags wrong");
   property p_master_clear_pin; !i_master_clear_pin_n |=> o_core_reset && !o_sleeping && $stable(o_timeout_flag) &&
      $stable(o_powerdown_flag) && o_prescaler_config == CFG_RESET_VALUE; endproperty
   a_master_clear_pin: assert property (p_master_clear_pin) else $error("master clear reset wrong");
   property p_freeze; o_sleeping && $past(o_sleeping) |-> $stable(o_port_out) && $stable(o_port_oe); endproperty
   a_freeze: assert property (p_freeze) else $error("pins moved in sleep");
   property p_pin; o_master_clear_pin_oe == 1'b0; endproperty
   a_pin: assert property (p_pin) else $error("master clear pin driven");
   c_sleep: cover property (i_sleep_instr && run);
   c_to: cover property (o_watchdog_timeout && $past(o_sleeping));
   c_wake: cover property (!i_master_clear_pin_n && o_sleeping);
endmodule
bind watchdog_reset_sleep_control wrs_checker #(.RESET_DELAY_CNT(RESET_DELAY_CNT), .PIN_COUNT(PIN_COUNT)) i_chk (
   .i_ref_clk, .i_reset, .i_master_clear_pin_n, .i_watchdog_enable_fuse, .i_watchdog_clear_instr, .i_sleep_instr,
   .o_core_reset, .o_timeout_flag, .o_powerdown_flag, .o_sleeping, .o_osc_driver_en, .o_watchdog_timeout,
   .o_prescaler_config, .o_port_out, .o_port_oe, .o_master_clear_pin_oe);
`default_nettype wire

/* File: verification/core_model.sv */
// Core model issuing sleep and watchdog clear pulses
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input  wire logic i_ref_clk,
   output logic      o_sleep_instr,
   output logic      o_clear_instr
);
   initial begin
      o_sleep_instr = 1'b0;
      o_clear_instr = 1'b0;
   end
   // Prompt or slow issue, one-cycle pulse
   task issue(input logic [1:0] op);
      repeat ($urandom_range(1, 3)) @(negedge i_ref_clk);
      o_sleep_instr = op[0];
      o_clear_instr = op[1];
      @(negedge i_ref_clk);
      o_sleep_instr = 1'b0;
      o_clear_instr = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the reset, watchdog and sleep block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import watchdog_reset_sleep_pkg::*;
   localparam int unsigned DLY = 20;
   localparam int unsigned WDC = 10;
   logic clk, rst, master_clear_pin_n, fuse, cfg_wr, clr, slp, prev_rst = 1;
   logic [5:0]  cfg, cfg_q;
   logic [11:0] pout, poe, pout_q, poe_q;
   logic [23:0] old;
   logic        core_rst, to_f, pd_f, slping, osc_en, wd_to, master_clear_pin_oe;
   logic [1:0]  exp_q[$];
   int          error_cnt = 0, checked = 0, n;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   core_model core (.i_ref_clk(clk), .o_sleep_instr(slp), .o_clear_instr(clr));
   watchdog_reset_sleep_control #(.RESET_DELAY_CNT(DLY), .WATCHDOG_CNT(WDC)) i_dut (
      .i_ref_clk(clk), .i_reset(rst), .i_master_clear_pin_n(master_clear_pin_n), .i_watchdog_enable_fuse(fuse),
      .i_watchdog_clear_instr(clr), .i_sleep_instr(slp), .i_prescaler_config_wr(cfg_wr),
      .i_prescaler_config_data(cfg), .i_port_out(pout), .i_port_oe(poe), .o_core_reset(core_rst),
      .o_timeout_flag(to_f), .o_powerdown_flag(pd_f), .o_sleeping(slping), .o_osc_driver_en(osc_en),
      .o_watchdog_timeout(wd_to), .o_prescaler_config(cfg_q), .o_port_out(pout_q), .o_port_oe(poe_q),
      .o_master_clear_pin_oe(master_clear_pin_oe));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task results;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task wait_for(input logic which, input int lim);
      n = 0;
      while ((which ? wd_to : !core_rst) !== 1'b1) begin
         @(posedge clk);
         #1 n++;
         if (n > lim) begin
            error_cnt++;
            $display("[ERR] %0t wait ran out", $time);
            results();
         end
      end
      @(negedge clk);
   endtask
   task cfg_write(input logic [5:0] v);
      @(negedge clk);
      cfg = v;
      cfg_wr = 1;
      @(negedge clk);
      cfg_wr = 0;
   endtask
   // Flags at each exit from reset against the noted cause
   always @(posedge clk) begin
      #1 if (prev_rst === 1'b1 && core_rst === 1'b0) chk({to_f, pd_f}, exp_q.pop_front());
      prev_rst = core_rst;
   end
   initial begin
      n = $urandom(54);
      rst = 1'b1;
      master_clear_pin_n = 1'b1;
      fuse = 1'b1;
      cfg_wr = 1'b0;
      cfg = 6'h00;
      {pout, poe} = $urandom();
      exp_q.push_back(2'b11);
      repeat (16) @(negedge clk);
      rst = 0;
      wait_for(0, 100);
      chk(n >= DLY && n <= DLY + 2, 1);
      chk(cfg_q, CFG_RESET_VALUE);
      $display("power-up test done");
      cfg_write(6'h00);
      chk(cfg_q, 6'h00);
      repeat (6) core.issue(2'b10);
      chk(core_rst, 0);
      exp_q.push_back(2'b01);
      wait_for(1, 50);
      wait_for(0, 100);
      $display("clear and time-out test done");
      for (int r = 0; r < 4; r++) begin
         cfg_write({2'($urandom()), 1'b1, 3'(r)});
         exp_q.push_back(2'b01);
         core.issue(2'b10);
         wait_for(1, 2000);
         chk(n >= (WDC << r) - 2 && n <= (WDC << r) + (1 << r) + 4, 1);
         wait_for(0, 100);
      end
      $display("prescaler test done");
      cfg_write(6'h00);
      fuse = 0;
      repeat (60) @(negedge clk);
      chk(core_rst, 0);
      core.issue(2'b10);
      fuse = 1;
      old = {pout, poe};
      core.issue(2'b01);
      chk({slping, osc_en, to_f, pd_f}, 4'b1010);
      {pout, poe} = $urandom();
      exp_q.push_back(2'b00);
      repeat (2) @(negedge clk);
      chk({pout_q, poe_q}, old);
      wait_for(1, 30);
      wait_for(0, 100);
      $display("sleep time-out test done");
      core.issue(2'b01);
      exp_q.push_back(2'b10);
      for (int k = 0; k < 2; k++) begin
         master_clear_pin_n = 0;
         repeat (3) @(negedge clk);
         master_clear_pin_n = 1;
         wait_for(0, 100);
         exp_q.push_back(2'b10);
      end
      chk(master_clear_pin_oe, 0);
      $display("master clear test done");
      results();
   end
endmodule
`default_nettype wire
